// ---- logic/clcp_reg_decode.sv ----
// register decode for the control list current pointer
// assumes register accesses are synchronous to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
module clcp_reg_decode (
    // access
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    // decode
    output logic hit_wr_out,
    output logic hit_rd_out
);
    wire addr_hit = (reg_addr_in == clcp_pkg::CLCP_PTR_OFFSET);
    assign hit_wr_out = reg_wr_in && addr_hit;
    assign hit_rd_out = reg_rd_in && addr_hit;
endmodule : clcp_reg_decode
`default_nettype wire

// ---- logic/clcp_top.sv ----
// control list current pointer register and its list-walk updates
// assumes the list walker, head pointer and control/status registers live outside
`timescale 1ns/1ps
`default_nettype none
// Operation
// - the descriptor address occupies bits 31 to 4 and bits 3 to 0 are reserved.
// - after serving the referenced descriptor the pointer moves to the next descriptor.
// - a new frame resumes at the descriptor where the last frame stopped, not at the head.
// - at the list end the controller looks at the list-filled flag, bit 1 of command status.
// - at the list end a set filled flag loads the head pointer and clears the flag, else nothing.
// - reset leaves the pointer at zero and a zero pointer means end of list.
module clcp_top #(
    parameter int unsigned PTR_W = clcp_pkg::CLCP_PTR_W
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    // control and command status bits from outside
    input wire logic [31:0] controller_control_register_in,
    input wire logic [31:0] command_status_register_in,
    input wire logic [31:0] control_list_head_pointer_in,
    // list walker
    input wire logic frame_start_in,
    input wire logic descriptor_served_in,
    input wire logic [31:0] next_descriptor_in,
    input wire logic list_end_in,
    // status
    output logic control_list_filled_clear_out,
    output logic at_end_of_list_out,
    output logic [31:0] resume_pointer_out
);
    logic hit_wr;
    logic hit_rd;
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_d;
    logic [31:0] rdata_q;
    logic clr_q;
    logic end_q;
    logic [31:0] resume_q;
    clcp_pkg::clcp_state_t state_q;
    clcp_pkg::clcp_state_t state_d;

    // pulls the 16-byte aligned descriptor address out of a bus word
    function automatic logic [PTR_W-1:0] addr_field(input logic [31:0] word);
        return PTR_W'(word >> clcp_pkg::CLCP_PTR_LSB);
    endfunction : addr_field

    clcp_reg_decode u_dec (
        .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .hit_wr_out(hit_wr),
        .hit_rd_out(hit_rd)
    );

    wire list_enable = controller_control_register_in[clcp_pkg::CLCP_CTRL_ENABLE_BIT];
    wire filled = command_status_register_in[clcp_pkg::CLCP_CMDSTAT_FILLED_BIT];
    wire sw_write = hit_wr && !list_enable;
    wire reload = list_end_in && filled;
    wire [PTR_W-1:0] head_addr = addr_field(control_list_head_pointer_in);
    wire [PTR_W-1:0] next_addr = addr_field(next_descriptor_in);
    wire [PTR_W-1:0] wr_addr = addr_field(reg_wdata_in);
    wire [31:0] ptr_word = {ptr_q, clcp_pkg::CLCP_RSVD_VALUE};

    // frame_start_in deliberately leaves the pointer alone
    assign ptr_d = sw_write ? wr_addr :
                   reload ? head_addr :
                   (descriptor_served_in && !list_end_in) ? next_addr :
                   ptr_q;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ptr_q <= addr_field(clcp_pkg::CLCP_PTR_RESET);
            rdata_q <= clcp_pkg::CLCP_PTR_RESET;
            clr_q <= 1'b0;
            end_q <= 1'b1;
            resume_q <= clcp_pkg::CLCP_PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
            rdata_q <= hit_rd ? ptr_word : 32'h0000_0000;
            clr_q <= reload;
            end_q <= (ptr_d == clcp_pkg::CLCP_END_OF_LIST);
            if (frame_start_in) begin
                resume_q <= ptr_word;
            end
        end
    end

    // walk phase within a frame: idle before the first frame, serving, then parked at the list end
    always_comb begin
        state_d = state_q;
        case (state_q)
            clcp_pkg::CLCP_ST_IDLE: begin
                if (frame_start_in) begin
                    state_d = clcp_pkg::CLCP_ST_SERVE;
                end
            end
            clcp_pkg::CLCP_ST_SERVE: begin
                if (list_end_in) begin
                    state_d = clcp_pkg::CLCP_ST_FRAME_DONE;
                end
            end
            clcp_pkg::CLCP_ST_FRAME_DONE: begin
                if (frame_start_in) begin
                    state_d = clcp_pkg::CLCP_ST_SERVE;
                end
            end
            default: begin
                state_d = clcp_pkg::CLCP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_q <= clcp_pkg::CLCP_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign control_list_filled_clear_out = clr_q;
    assign at_end_of_list_out = end_q;
    assign resume_pointer_out = resume_q;

    // named steps of the list-walk updates
    sequence s_write_request;
        sw_write;
    endsequence
    sequence s_reload_request;
        list_end_in && filled && !sw_write;
    endsequence
    sequence s_reload_taken;
        (ptr_q == $past(head_addr)) && control_list_filled_clear_out;
    endsequence
    sequence s_clear_dropped;
        !control_list_filled_clear_out;
    endsequence
    sequence s_advance_request;
        descriptor_served_in && !list_end_in && !sw_write;
    endsequence
    sequence s_advance_taken;
        ptr_q == $past(next_addr);
    endsequence

    // pointer update checks
    a_write_locked: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (hit_wr && list_enable && !reload && !descriptor_served_in) |=> $stable(ptr_q))
        else $error("pointer changed by a write while list enabled");
    a_reload_head: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_reload_request |=> s_reload_taken)
        else $error("list end with filled flag did not reload head");
    a_clear_pulse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (s_reload_request ##1 !reload) |=> s_clear_dropped)
        else $error("filled flag clear pulse lasted too long");
    a_clear_cause: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        control_list_filled_clear_out |-> $past(reload))
        else $error("filled flag clear without a reload");
    a_no_reload: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (list_end_in && !filled && !sw_write) |=> $stable(ptr_q) && !control_list_filled_clear_out)
        else $error("list end without filled flag changed pointer");
    a_advance_next: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_advance_request |=> s_advance_taken)
        else $error("pointer did not advance");
    a_frame_resume: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (frame_start_in && !descriptor_served_in && !list_end_in && !sw_write) |=> $stable(ptr_q))
        else $error("frame start moved the pointer");
    a_rsvd_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        reg_rdata_out[3:0] == 4'h0)
        else $error("reserved bits read nonzero");
    a_read_value: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        hit_rd |=> reg_rdata_out[31:4] == $past(ptr_q))
        else $error("read data does not match pointer");
    a_end_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        at_end_of_list_out == (ptr_q == clcp_pkg::CLCP_END_OF_LIST))
        else $error("end flag disagrees with zero pointer");

    // end-of-list flag and ordering checks
    a_served_at_end: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (descriptor_served_in && list_end_in && !filled && !sw_write) |=> $stable(ptr_q))
        else $error("pointer advanced past the list end");
    a_sw_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_write_request |=> ptr_q == $past(wr_addr))
        else $error("software write did not land while list disabled");
    a_write_end_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_write_request |=> at_end_of_list_out == ($past(wr_addr) == clcp_pkg::CLCP_END_OF_LIST))
        else $error("end flag wrong after software write");
    a_advance_end_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (descriptor_served_in && !list_end_in && !sw_write && (next_addr != clcp_pkg::CLCP_END_OF_LIST))
            |=> !at_end_of_list_out)
        else $error("end flag set after advancing to a nonzero descriptor");
    a_head_end_flag: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_reload_request |=> at_end_of_list_out == ($past(head_addr) == clcp_pkg::CLCP_END_OF_LIST))
        else $error("end flag wrong after head reload");
    // frame and resume checks
    a_resume_capture: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        frame_start_in |=> resume_pointer_out == $past(ptr_word))
        else $error("frame start did not capture the pointer");
    a_resume_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !frame_start_in |=> $stable(resume_pointer_out))
        else $error("resume pointer changed between frame starts");
    a_end_no_action: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_q == clcp_pkg::CLCP_ST_SERVE && list_end_in && !filled && !sw_write)
            |=> (state_q == clcp_pkg::CLCP_ST_FRAME_DONE) && $stable(ptr_q))
        else $error("list end without filled flag did not park the walk");
    a_idle_resume: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_q == clcp_pkg::CLCP_ST_IDLE) |-> resume_pointer_out == clcp_pkg::CLCP_PTR_RESET)
        else $error("resume pointer moved before the first frame");
    // read side checks
    a_locked_read: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (hit_rd && list_enable) |=> reg_rdata_out == $past(ptr_word))
        else $error("read while list enabled did not show the momentary pointer");
    a_read_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !hit_rd |=> reg_rdata_out == 32'h0000_0000)
        else $error("read data not zero without a pointer read");
    // reset is checked without the disable used above
    a_reset_state: assert property (@(posedge sys_clk_in)
        reset_in |=> (ptr_q == clcp_pkg::CLCP_END_OF_LIST) && at_end_of_list_out
            && !control_list_filled_clear_out)
        else $error("reset did not clear the pointer");
endmodule : clcp_top
`default_nettype wire

// ---- shared/clcp_pkg.sv ----
// package for the control list current pointer register block
// assumes one 100 MHz clock domain and a synchronous active-high reset
package clcp_pkg;
    localparam int unsigned CLCP_DATA_W = 32;
    localparam int unsigned CLCP_ADDR_W = 8;
    localparam logic [7:0] CLCP_PTR_OFFSET = 8'h24;
    localparam int unsigned CLCP_PTR_LSB = 4;
    localparam int unsigned CLCP_PTR_W = 28;
    localparam logic [31:0] CLCP_PTR_RESET = 32'h0000_0000;
    localparam logic [27:0] CLCP_END_OF_LIST = 28'h000_0000;
    localparam logic [3:0] CLCP_RSVD_VALUE = 4'h0;
    localparam int unsigned CLCP_CMDSTAT_FILLED_BIT = 1;
    localparam int unsigned CLCP_CTRL_ENABLE_BIT = 4;
    typedef enum logic [1:0] {
        CLCP_ST_IDLE,
        CLCP_ST_SERVE,
        CLCP_ST_FRAME_DONE
    } clcp_state_t;
endpackage : clcp_pkg

// ---- testbench/control_list_current_pointer_bench.sv ----
// self-checking bench for the control list current pointer register block
// assumes clcp_top carries its own assertions; one 100 MHz clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module control_list_current_pointer_bench;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fs = 1'b0, srv = 1'b0, le = 1'b0, clr, eol;
    logic [7:0] addr = 8'h24;
    logic [31:0] wd = 32'h0, ctl = 32'h0, cst = 32'h0, head = 32'h0, nxt = 32'h0, rdata, resume, v;
    int mismatches = 0, check_count = 0;
    always #5 clk = ~clk;
    clcp_top dut (.sys_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wd), .reg_rdata_out(rdata), .controller_control_register_in(ctl),
        .command_status_register_in(cst), .control_list_head_pointer_in(head), .frame_start_in(fs),
        .descriptor_served_in(srv), .next_descriptor_in(nxt), .list_end_in(le),
        .control_list_filled_clear_out(clr), .at_end_of_list_out(eol), .resume_pointer_out(resume));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic t_reset_and_write;
        rd_reg(8'h24);
        chk(v, 32'h0);
        chk({31'h0, eol}, 32'h1);
        wr_reg(8'h24, 32'habcd_123f);
        rd_reg(8'h24);
        chk(v, 32'habcd_1230);
        chk({31'h0, eol}, 32'h0);
        rd_reg(8'h28);
        chk(v, 32'h0);
        ctl <= 32'h10;
        wr_reg(8'h24, 32'h0000_5550);
        rd_reg(8'h24);
        chk(v, 32'habcd_1230);
        ctl <= 32'h0;
    endtask : t_reset_and_write
    task automatic t_walk;
        @(posedge clk);
        nxt <= 32'h0000_2000;
        srv <= 1'b1;
        @(posedge clk);
        srv <= 1'b0;
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        #1 chk(resume, 32'h0000_2000);
        rd_reg(8'h24);
        chk(v, 32'h0000_2000);
    endtask : t_walk
    task automatic t_list_end(input logic [31:0] status, input logic [31:0] exp);
        @(posedge clk);
        cst <= status;
        head <= 32'h0000_4440;
        nxt <= 32'h0000_9990;
        srv <= 1'b1;
        le <= 1'b1;
        @(posedge clk);
        srv <= 1'b0;
        le <= 1'b0;
        #1 chk({31'h0, clr}, {31'h0, status[1]});
        @(posedge clk);
        #1 chk({31'h0, clr}, 32'h0);
        rd_reg(8'h24);
        chk(v, exp);
    endtask : t_list_end
    task automatic t_mid_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk({31'h0, eol}, 32'h1);
        chk(resume, 32'h0);
        rd_reg(8'h24);
        chk(v, 32'h0);
    endtask : t_mid_reset
    task automatic final_report;
        if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset_and_write();
        t_walk();
        t_list_end(32'h0, 32'h0000_2000);
        t_list_end(32'h2, 32'h0000_4440);
        t_mid_reset();
        final_report();
    end
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule : control_list_current_pointer_bench
`default_nettype wire
